// ===== core/timer_defines.vh
// Register map, field positions, reset values and divider counts of the dual timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// ****************************************************************************
// Register pair codes on bus_addr[2:1]; each pair is channel 0 at the even address, channel 1 odd
// ****************************************************************************
`define ADDR_CTRL      2'h0
`define ADDR_STATUS    2'h1
`define ADDR_CONST_A   2'h2
`define ADDR_COUNT     2'h3
// ****************************************************************************
// Control register fields
// ****************************************************************************
`define CSEL_MSB       2
`define CSEL_LSB       0
`define CLR_MSB        4
`define CLR_LSB        3
`define CTRL_MASK      8'h1F
// Clock select codes
`define CSEL_STOP      3'h0
`define CSEL_DIV_A     3'h1
`define CSEL_DIV_B     3'h2
`define CSEL_DIV_C     3'h3
`define CSEL_EXT_RISE  3'h5
`define CSEL_EXT_FALL  3'h6
`define CSEL_EXT_BOTH  3'h7
// Clear select codes
`define CLR_NONE       2'h0
`define CLR_MATCH      2'h1
`define CLR_EXT        2'h3
// ****************************************************************************
// Control/status register fields
// ****************************************************************************
`define WRAP_BIT       5
`define MATCH_BIT      6
`define OS_MSB         1
`define OS_LSB         0
`define STATUS_MASK    8'h03
// Output select codes
`define OS_HOLD        2'h0
`define OS_LOW         2'h1
`define OS_HIGH        2'h2
`define OS_TOGGLE      2'h3
// ****************************************************************************
// Reset values and the counter's all-ones maximum
// ****************************************************************************
`define COUNT_RESET    8'h00
`define CONST_RESET    8'hFF
`define CTRL_RESET     8'h00
`define STATUS_RESET   8'h00
`define COUNT_MAX      8'hFF
// ****************************************************************************
// Prescaler taps: internal rates of clock/8, clock/64 and clock/8192
// ****************************************************************************
`define PRESC_W        13
`define TAP_A_W        3
`define TAP_B_W        6
`define TAP_C_W        13
`endif

// ===== core/timer_channel.v
// One 8-bit counter with its compare constant A, flags events and timer output
`timescale 1ns/10ps
`include "timer_defines.vh"
module timer_channel #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_b,
  input  wire             standby,
  // Count, clear and output control
  input  wire             tick,
  input  wire             ext_clear,
  input  wire [1:0]       clr_sel,
  input  wire [1:0]       out_sel,
  // Processor writes
  input  wire             cnt_wr,
  input  wire             const_wr,
  input  wire [WIDTH-1:0] wdata,
  // State and events
  output reg  [WIDTH-1:0] cnt_q,
  output reg  [WIDTH-1:0] const_q,
  output wire             match_evt,
  output wire             wrap_evt,
  output reg              tmr_out_q
);
  // ****************************************************************************
  // Compare and overflow, judged on the counting edge only
  // ****************************************************************************
  reg              suppress_q;
  reg  [WIDTH-1:0] cnt_d;
  wire             equal;
  wire             clr_match;

  // Write to the constant blanks the compare in the following state
  assign equal     = (cnt_q == const_q) && !suppress_q;                  // RULE9 RULE10
  // Events only on a count pulse, so each flag sets once per event
  assign match_evt = tick && equal;                                     // RULE13
  assign clr_match = match_evt && (clr_sel == `CLR_MATCH);
  assign wrap_evt  = tick && !clr_match && (cnt_q == `COUNT_MAX);       // RULE5 RULE13

  always @* begin
    cnt_d = cnt_q;
    if (cnt_wr) begin
      cnt_d = wdata;                                                    // RULE2
    end else if (ext_clear && (clr_sel == `CLR_EXT)) begin
      cnt_d = `COUNT_RESET;                                             // RULE4
    end else if (clr_match) begin
      cnt_d = `COUNT_RESET;                                             // RULE4
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;                                             // RULE1
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q      <= `COUNT_RESET;                                       // RULE6
      const_q    <= `CONST_RESET;                                       // RULE12
      suppress_q <= 1'b0;
      tmr_out_q  <= 1'b0;
    end else if (standby) begin
      cnt_q      <= `COUNT_RESET;                                       // RULE6
      const_q    <= `CONST_RESET;                                       // RULE12
      suppress_q <= 1'b0;
      tmr_out_q  <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      suppress_q <= const_wr;                                           // RULE10
      if (const_wr) begin
        const_q <= wdata;                                               // RULE7
      end
      if (match_evt) begin
        case (out_sel)                                                  // RULE11
          `OS_LOW:    tmr_out_q <= 1'b0;
          `OS_HIGH:   tmr_out_q <= 1'b1;
          `OS_TOGGLE: tmr_out_q <= ~tmr_out_q;
          default:    tmr_out_q <= tmr_out_q;
        endcase
      end
    end
  end
endmodule // timer_channel

// ===== core/dual_timer.v
// Dual 8-bit timer with compare constant A, prescaler and processor register port
//
// Overview of operation
// RULE1: Each counter is 8 bits and counts up on pulses from the selected clock.
// RULE2: The processor may read and write both counters at any time.
// RULE3: Both counters pair into one 16-bit word for a single word transfer.
// RULE4: A counter clears on external reset or compare match, per clear field.
// RULE5: Counter wrapping from all ones to zero sets the overflow flag.
// RULE6: Counters go to zero on reset and during hardware standby.
// RULE7: Each compare constant A is an 8-bit readable, writable register.
// RULE8: Both compare constants pair into one 16-bit word for word transfers.
// RULE9: Constant and counter are compared always; equality sets match flag A.
// RULE10: Compare is blanked in the second state of a constant write.
// RULE11: Timer output follows compare matches as the output select field says.
// RULE12: Compare constants go to all ones on reset and hardware standby.
// RULE13: Match and overflow are judged on the counting edge, once per event.
`timescale 1ns/10ps
`include "timer_defines.vh"
module dual_timer #(
  parameter CHANNELS = 2,
  parameter WIDTH    = 8
) (
  // Clock and reset
  input  wire                  clock,
  input  wire                  rst_b,
  input  wire                  hw_standby,
  // Processor register port
  input  wire                  bus_req,
  input  wire                  bus_wr,
  input  wire                  bus_word,
  input  wire [2:0]            bus_addr,
  input  wire [15:0]           bus_wdata,
  output reg  [15:0]           bus_rdata,
  output reg                   bus_ack,
  // External timer pins
  input  wire [CHANNELS-1:0]   ext_clk,
  input  wire [CHANNELS-1:0]   ext_rst,
  output wire [CHANNELS-1:0]   tmr_out
);
  // ****************************************************************************
  // Bus decode
  // ****************************************************************************
  wire [1:0] reg_sel;
  wire       wr_go;

  assign reg_sel = bus_addr[2:1];
  assign wr_go   = bus_req && bus_wr;

  // ****************************************************************************
  // Prescaler shared by both channels
  // ****************************************************************************
  reg  [`PRESC_W-1:0] presc_q;
  wire                tap_a;
  wire                tap_b;
  wire                tap_c;

  // One free-running divider keeps the two channels phase aligned
  assign tap_a = &presc_q[`TAP_A_W-1:0];
  assign tap_b = &presc_q[`TAP_B_W-1:0];
  assign tap_c = &presc_q[`TAP_C_W-1:0];

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      presc_q <= {`PRESC_W{1'b0}};
    end else if (hw_standby) begin
      presc_q <= {`PRESC_W{1'b0}};
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // ****************************************************************************
  // External pin history for edge detection
  // ****************************************************************************
  reg [CHANNELS-1:0] ext_clk_q;
  reg [CHANNELS-1:0] ext_rst_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk_q <= {CHANNELS{1'b0}};
      ext_rst_q <= {CHANNELS{1'b0}};
    end else begin
      ext_clk_q <= ext_clk;
      ext_rst_q <= ext_rst;
    end
  end

  // ****************************************************************************
  // Per-channel control, status and counter
  // ****************************************************************************
  wire [CHANNELS*8-1:0]     ctrl_rd;
  wire [CHANNELS*8-1:0]     status_rd;
  wire [CHANNELS*WIDTH-1:0] cnt_all;
  wire [CHANNELS*WIDTH-1:0] const_all;

  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      reg  [7:0]       ctrl_q;
      reg              wrap_q;
      reg              match_q;
      reg  [1:0]       os_q;
      reg              tick;
      wire             sel;
      wire [7:0]       wbyte;
      wire             rise;
      wire             fall;
      wire             match_evt;
      wire             wrap_evt;
      wire [WIDTH-1:0] cnt_q;
      wire [WIDTH-1:0] const_q;

      // Word transfers hit both channels; channel 0 sits in the upper byte
      assign sel   = bus_word || (bus_addr[0] == (i == 1));              // RULE3 RULE8
      assign wbyte = (bus_word && (i == 0)) ? bus_wdata[15:8] : bus_wdata[7:0];
      assign rise  = ext_clk[i] && !ext_clk_q[i];
      assign fall  = !ext_clk[i] && ext_clk_q[i];

      always @* begin
        case (ctrl_q[`CSEL_MSB:`CSEL_LSB])                              // RULE1
          `CSEL_DIV_A:    tick = tap_a;
          `CSEL_DIV_B:    tick = tap_b;
          `CSEL_DIV_C:    tick = tap_c;
          `CSEL_EXT_RISE: tick = rise;
          `CSEL_EXT_FALL: tick = fall;
          `CSEL_EXT_BOTH: tick = rise || fall;
          default:       tick = 1'b0;
        endcase
      end

      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          ctrl_q  <= `CTRL_RESET;
          wrap_q  <= 1'b0;
          match_q <= 1'b0;
          os_q    <= 2'h0;
        end else if (hw_standby) begin
          ctrl_q  <= `CTRL_RESET;
          wrap_q  <= 1'b0;
          match_q <= 1'b0;
          os_q    <= 2'h0;
        end else begin
          if (wr_go && sel && (reg_sel == `ADDR_CTRL)) begin
            ctrl_q <= wbyte & `CTRL_MASK;
          end
          if (wr_go && sel && (reg_sel == `ADDR_STATUS)) begin
            os_q <= wbyte[`OS_MSB:`OS_LSB];
          end
          // A new event wins over a clear written in the same cycle
          if (wrap_evt) begin
            wrap_q <= 1'b1;                                             // RULE5
          end else if (wr_go && sel && (reg_sel == `ADDR_STATUS) && !wbyte[`WRAP_BIT]) begin
            wrap_q <= 1'b0;
          end
          if (match_evt) begin
            match_q <= 1'b1;                                            // RULE9
          end else if (wr_go && sel && (reg_sel == `ADDR_STATUS) && !wbyte[`MATCH_BIT]) begin
            match_q <= 1'b0;
          end
        end
      end

      timer_channel #(
        .WIDTH (WIDTH)
      ) u_chan (
        .clock     (clock),
        .rst_b     (rst_b),
        .standby   (hw_standby),
        .tick      (tick),
        .ext_clear (ext_rst[i] && !ext_rst_q[i]),
        .clr_sel   (ctrl_q[`CLR_MSB:`CLR_LSB]),
        .out_sel   (os_q),
        .cnt_wr    (wr_go && sel && (reg_sel == `ADDR_COUNT)),
        .const_wr  (wr_go && sel && (reg_sel == `ADDR_CONST_A)),
        .wdata     (wbyte[WIDTH-1:0]),
        .cnt_q     (cnt_q),
        .const_q   (const_q),
        .match_evt (match_evt),
        .wrap_evt  (wrap_evt),
        .tmr_out_q (tmr_out[i])
      );

      assign ctrl_rd[i*8 +: 8]           = ctrl_q;
      assign status_rd[i*8 +: 8]         = {1'b0, match_q, wrap_q, 3'h0, os_q};
      assign cnt_all[i*WIDTH +: WIDTH]   = cnt_q;
      assign const_all[i*WIDTH +: WIDTH] = const_q;
    end
  endgenerate

  // ****************************************************************************
  // Read data and acknowledge
  // ****************************************************************************
  reg [7:0] byte0;
  reg [7:0] byte1;

  always @* begin
    case (reg_sel)
      `ADDR_CTRL: begin
        byte0 = ctrl_rd[7:0];
        byte1 = ctrl_rd[15:8];
      end
      `ADDR_STATUS: begin
        byte0 = status_rd[7:0];
        byte1 = status_rd[15:8];
      end
      `ADDR_CONST_A: begin
        byte0 = const_all[7:0];                                         // RULE7
        byte1 = const_all[15:8];
      end
      `ADDR_COUNT: begin
        byte0 = cnt_all[7:0];                                           // RULE2
        byte1 = cnt_all[15:8];
      end
      default: begin
        byte0 = 8'h00;
        byte1 = 8'h00;
      end
    endcase
  end

  // Read data is sampled in the first state and shown in the second
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
      bus_ack   <= 1'b0;
    end else begin
      bus_ack <= bus_req;
      if (bus_req && !bus_wr) begin
        if (bus_word) begin
          bus_rdata <= {byte0, byte1};                                  // RULE3 RULE8
        end else if (bus_addr[0]) begin
          bus_rdata <= {8'h00, byte1};
        end else begin
          bus_rdata <= {8'h00, byte0};
        end
      end
    end
  end
endmodule // dual_timer

// ===== tb/dual_timer_properties.sv
// Port-level checker for the dual timer
`timescale 1ns/10ps
module dual_timer_properties #(
  parameter CHANNELS = 2
) (
  // Clock and reset
  input wire                clock,
  input wire                rst_b,
  input wire                hw_standby,
  // Register port
  input wire                bus_req,
  input wire                bus_wr,
  input wire                bus_word,
  input wire [2:0]          bus_addr,
  input wire [15:0]         bus_wdata,
  input wire [15:0]         bus_rdata,
  input wire                bus_ack,
  // Pins
  input wire [CHANNELS-1:0] ext_clk,
  input wire [CHANNELS-1:0] ext_rst,
  input wire [CHANNELS-1:0] tmr_out
);
  // ********
  // Properties
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rd_byte;
    bus_req && !bus_wr && !bus_word;
  endsequence
  // Second standby cycle, so the held values have landed before the read
  sequence s_sb_rd(pair);
    hw_standby ##1 (hw_standby && bus_req && !bus_wr && bus_word && bus_addr[2:1] == pair);
  endsequence
  a_ack_after_req: assert property (bus_req |=> bus_ack)
    else $error("no answer one cycle after a request");
  a_ack_has_cause: assert property (!bus_req |=> !bus_ack)
    else $error("answer without a request");
  a_rdata_holds: assert property ((!bus_req || bus_wr) |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_byte_upper_zero: assert property (s_rd_byte |=> bus_rdata[15:8] == 8'h00)
    else $error("byte read upper half not zero");
  a_ctrl_top_zero: assert property (s_rd_byte ##0 bus_addr[2:1] == 2'h0
    |=> bus_rdata[7:5] == 3'h0) else $error("control read top bits not zero");
  a_standby_const: assert property (s_sb_rd(2'h2) |=> bus_rdata == 16'hFFFF)
    else $error("constants not all ones in standby");
  a_standby_count: assert property (s_sb_rd(2'h3) |=> bus_rdata == 16'h0000)
    else $error("counters not zero in standby");
  a_standby_out: assert property (hw_standby |=> tmr_out == '0)
    else $error("timer output not low in standby");
endmodule // dual_timer_properties
bind dual_timer dual_timer_properties #(.CHANNELS(CHANNELS)) u_props (
  .clock(clock), .rst_b(rst_b), .hw_standby(hw_standby), .bus_req(bus_req),
  .bus_wr(bus_wr), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .ext_clk(ext_clk), .ext_rst(ext_rst),
  .tmr_out(tmr_out));

// ===== tb/timer_pins.sv
// Far-side pin model: external count clocks and clear pulses
`timescale 1ns/10ps
module timer_pins (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_b,
  // Bench requests
  input  wire [1:0] go,
  input  wire [1:0] clr,
  // Pins
  output wire [1:0] ext_clk,
  output reg  [1:0] ext_rst
);
  // ********
  // Pin drive
  // ********
  reg [1:0] ph0_q;
  reg [1:0] ph1_q;
  // Two cycles high, two low, so every edge is seen by the sampling logic
  assign ext_clk = {ph1_q[1], ph0_q[1]};
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ph0_q <= 2'h0;
      ph1_q <= 2'h0;
      ext_rst <= 2'h0;
    end else begin
      ph0_q <= go[0] ? ph0_q + 2'h1 : 2'h0;
      ph1_q <= go[1] ? ph1_q + 2'h1 : 2'h0;
      ext_rst <= clr;
    end
  end
endmodule // timer_pins

// ===== tb/tb_dual_timer.sv
// Self-checking bench for the dual timer
`timescale 1ns/10ps
module tb_dual_timer;
  reg         clock, rst_b, hw_standby, bus_req, bus_wr, bus_word;
  reg  [2:0]  bus_addr;
  reg  [15:0] bus_wdata;
  wire [15:0] bus_rdata;
  wire        bus_ack;
  wire [1:0]  ext_clk, ext_rst, tmr_out;
  reg  [1:0]  go, clr;
  reg  [31:0] q[$];
  reg  [31:0] e, rnd;
  integer     fails, n_compared, seed, i;
  dual_timer u_dual_timer (.clock(clock), .rst_b(rst_b), .hw_standby(hw_standby),
    .bus_req(bus_req), .bus_wr(bus_wr), .bus_word(bus_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .ext_clk(ext_clk), .ext_rst(ext_rst), .tmr_out(tmr_out));
  timer_pins u_timer_pins (.clock(clock), .rst_b(rst_b), .go(go), .clr(clr),
    .ext_clk(ext_clk), .ext_rst(ext_rst));
  // ********
  // Tasks
  // ********
  task chk(input [15:0] got, input [15:0] exp, input [15:0] m);
    begin
      n_compared = n_compared + 1;
      if ((got & m) !== (exp & m)) begin
        fails = fails + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got & m, exp & m);
      end
    end
  endtask
  // Request stays up across calls, so consecutive accesses go back to back
  task acc(input w, input wd, input [2:0] a, input [15:0] d, input [15:0] x, input [15:0] m);
    begin
      bus_req = 1'b1;
      bus_wr = w;
      bus_word = wd;
      bus_addr = a;
      bus_wdata = d;
      q.push_back({m, x});
      @(posedge clock);
      #1;
    end
  endtask
  task wr(input wd, input [2:0] a, input [15:0] d);
    acc(1'b1, wd, a, d, 16'h0000, 16'h0000);
  endtask
  task rd(input wd, input [2:0] a, input [15:0] x);
    acc(1'b0, wd, a, 16'h0000, x, 16'hFFFF);
  endtask
  task pins(input [1:0] g, input [1:0] c, input integer n);
    begin
      bus_req = 1'b0;
      go = g;
      clr = c;
      repeat (4 * n) @(posedge clock);
      #1;
      go = 2'h0;
      clr = 2'h0;
      repeat (6) @(posedge clock);
      #1;
    end
  endtask
  // Channel 0 sits at count 0x20 against constant 0x20; one rising pin edge makes a match
  task hit(input [1:0] o, input e);
    begin
      wr(1'b0, 3'h6, 16'h0020);
      wr(1'b0, 3'h2, {14'h0000, o});
      pins(2'h1, 2'h0, 1);
      chk({15'h0000, tmr_out[0]}, {15'h0000, e}, 16'h0001);
    end
  endtask
  // Standby zeroes the prescaler, so channel 1 counts from a known divider phase
  task presc(input [7:0] c, input integer n, input [15:0] x);
    begin
      bus_req = 1'b0;
      hw_standby = 1'b1;
      @(posedge clock);
      #1;
      hw_standby = 1'b0;
      wr(1'b0, 3'h1, {8'h00, c});
      bus_req = 1'b0;
      repeat (n) @(posedge clock);
      #1;
      wr(1'b0, 3'h1, 16'h0000);
      rd(1'b0, 3'h7, x);
      bus_req = 1'b0;
    end
  endtask
  task report_and_stop;
    begin
      $display("compared=%0d fails=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ********
  // Clock, monitor, watchdog
  // ********
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (bus_ack === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      if (e[31:16] != 16'h0000)
        chk(bus_rdata, e[15:0], e[31:16]);
    end
  end
  initial begin
    #200000;
    fails = fails + 1;
    report_and_stop;
  end
  // ********
  // Scenarios
  // ********
  initial begin
    {rst_b, hw_standby, bus_req, bus_wr, bus_word, bus_addr} = 8'h00;
    {bus_wdata, go, clr} = 20'h00000;
    fails = 0;
    n_compared = 0;
    seed = 32'hd6ba;
    repeat (5) @(posedge clock);
    #1 rst_b = 1'b1;
    rd(1'b1, 3'h6, 16'h0000);
    rd(1'b1, 3'h4, 16'hFFFF);
    rd(1'b0, 3'h1, 16'h0000);
    rd(1'b0, 3'h2, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = $random(seed);
      wr(1'b0, 3'h4, {8'h00, rnd[7:0]});
      wr(1'b0, 3'h5, {8'h00, rnd[15:8]});
      rd(1'b1, 3'h4, {rnd[7:0], rnd[15:8]});
      wr(1'b1, 3'h6, rnd[31:16]);
      rd(1'b0, 3'h7, {8'h00, rnd[23:16]});
      rd(1'b1, 3'h6, rnd[31:16]);
    end
    // Channel 0: clear on match, toggle output
    wr(1'b0, 3'h4, 16'h0003);
    wr(1'b0, 3'h6, 16'h0000);
    wr(1'b0, 3'h2, 16'h0003);
    wr(1'b0, 3'h0, 16'h000D);
    pins(2'h1, 2'h0, 4);
    rd(1'b0, 3'h6, 16'h0000);
    rd(1'b0, 3'h2, 16'h0043);
    chk({14'h0000, tmr_out}, 16'h0001, 16'h0001);
    wr(1'b0, 3'h2, 16'h0003);
    rd(1'b0, 3'h2, 16'h0003);
    pins(2'h1, 2'h0, 4);
    chk({14'h0000, tmr_out}, 16'h0000, 16'h0001);
    // Channel 1: wrap with a match at all ones, output driven high
    wr(1'b0, 3'h5, 16'h00FF);
    wr(1'b0, 3'h7, 16'h00FE);
    wr(1'b0, 3'h3, 16'h0002);
    wr(1'b0, 3'h1, 16'h0005);
    pins(2'h2, 2'h0, 2);
    rd(1'b0, 3'h7, 16'h0000);
    rd(1'b0, 3'h3, 16'h0062);
    chk({14'h0000, tmr_out}, 16'h0002, 16'h0002);
    wr(1'b0, 3'h1, 16'h0018);
    wr(1'b0, 3'h7, 16'h0055);
    pins(2'h0, 2'h2, 1);
    rd(1'b0, 3'h7, 16'h0000);
    // Standby: writes are lost and state returns to reset values
    hw_standby = 1'b1;
    wr(1'b0, 3'h4, 16'h0012);
    rd(1'b1, 3'h4, 16'hFFFF);
    rd(1'b1, 3'h6, 16'h0000);
    bus_req = 1'b0;
    hw_standby = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rd(1'b1, 3'h4, 16'hFFFF);
    rd(1'b0, 3'h0, 16'h0000);
    chk({14'h0000, tmr_out}, 16'h0000, 16'h0003);
    // Channel 0: the pulse right after a constant write must not match
    wr(1'b0, 3'h0, 16'h0005);
    go = 2'h1;
    wr(1'b0, 3'h6, 16'h0020);
    wr(1'b0, 3'h4, 16'h0020);
    go = 2'h0;
    bus_req = 1'b0;
    @(posedge clock);
    #1;
    rd(1'b0, 3'h2, 16'h0000);
    rd(1'b0, 3'h6, 16'h0021);
    // Channel 0: output drive high, hold, then low on matches
    hit(2'h2, 1'b1);
    hit(2'h0, 1'b1);
    hit(2'h1, 1'b0);
    rd(1'b0, 3'h2, 16'h0041);
    // Channel 1: both pin edges, then falling edges only
    wr(1'b0, 3'h7, 16'h0000);
    wr(1'b0, 3'h1, 16'h0007);
    pins(2'h2, 2'h0, 2);
    rd(1'b0, 3'h7, 16'h0004);
    wr(1'b0, 3'h7, 16'h0000);
    wr(1'b0, 3'h1, 16'h0006);
    pins(2'h2, 2'h0, 2);
    rd(1'b0, 3'h7, 16'h0002);
    // Channel 1: the three internal rates
    presc(8'h01, 18, 16'h0002);
    presc(8'h02, 98, 16'h0001);
    presc(8'h03, 8198, 16'h0001);
    pins(2'h0, 2'h0, 1);
    report_and_stop;
  end
endmodule // tb_dual_timer
